// ### sfc_map.svh
`ifndef SFC_MAP_SVH
`define SFC_MAP_SVH
`define SFC_A_MODE 8'h00
`define SFC_A_WAIT 8'h04
`define SFC_A_FC1 8'h08
`define SFC_A_FC2 8'h0C
`define SFC_A_EBS 8'h10
`define SFC_A_EBS2 8'h14
`define SFC_A_PADR 8'h18
`define SFC_A_PDAT 8'h1C
`define SFC_A_IST 8'h20
`define SFC_A_IEN 8'h24
`define SFC_A_ICLR 8'h28
`define SFC_B_EXPAND 7
`define SFC_B_GATE 4
`define SFC_B_FLASH_WE 7
`define SFC_B_SOFT_WE 6
`define SFC_B_ERASE_VFY 3
`define SFC_B_PROG_VFY 2
`define SFC_B_E 1
`define SFC_B_P 0
`define SFC_B_FAULT 7
`define SFC_B_ERASE_SU 1
`define SFC_B_PROG_SU 0
`define SFC_I_PDONE 0
`define SFC_I_EDONE 1
`define SFC_I_FAULT 2
`define SFC_WAIT_MASK 8'h3F
`define SFC_FC1_MASK 8'hCF
`define SFC_RST_BYTE 8'h00
`define SFC_RST_ADDR 16'h0000
`define SFC_RST_IRQ 3'b000
`define SFC_BOOT_PINS 5'b0_0111
`define SFC_BLK0_LO 16'h0000
`define SFC_BLK0_HI 16'h03FF
`define SFC_BLK1_LO 16'h0400
`define SFC_BLK1_HI 16'h07FF
`define SFC_BLK2_LO 16'h0800
`define SFC_BLK2_HI 16'h08FF
`define SFC_BLK3_LO 16'h0C00
`define SFC_BLK3_HI 16'h0FFF
`define SFC_BLK4_LO 16'h1000
`define SFC_BLK4_HI 16'h7FFF
`define SFC_BLK5_LO 16'h8000
`define SFC_BLK5_HI 16'hBFFF
`define SFC_BLK6_LO 16'hC000
`define SFC_BLK6_HI 16'hEF7F
`define SFC_BLK7_LO 16'hEF00
`define SFC_BLK7_HI 16'hF77F
`define SFC_CLK_NS 100
`define SFC_RESW_NS 2000
`define SFC_RESW_CYC ((`SFC_RESW_NS + `SFC_CLK_NS - 1) / `SFC_CLK_NS)
`define SFC_MDS_NS 400
`define SFC_MDS_CYC ((`SFC_MDS_NS + `SFC_CLK_NS - 1) / `SFC_CLK_NS)
`endif

// ### sfc_pkg.sv
package sfc_pkg;
  typedef enum logic [1:0] {SFC_IDLE, SFC_PROG, SFC_ERASE} sfc_state_type;
  typedef logic [7:0] sfc_byte_type;
  typedef logic [15:0] sfc_addr_type;
endpackage

// ### sfc_pgm_buffer.sv
module sfc_pgm_buffer #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 32
) (
  // Clock and reset.
  input wire logic clk,
  input wire logic rst_b,
  // Write port.
  input wire logic wr_en,
  input wire logic [$clog2(DEPTH)-1:0] wr_addr,
  input wire logic [WIDTH-1:0] wr_data,
  // Read port.
  input wire logic [$clog2(DEPTH)-1:0] rd_addr,
  output logic [WIDTH-1:0] rd_data
);
  logic [WIDTH-1:0] mem [DEPTH];

  if (DEPTH < 2 || WIDTH < 1) begin : g_chk
    $error("sfc_pgm_buffer: unsupported size");
  end

  always_ff @(posedge clk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      rd_data <= '0;
    end else begin
      rd_data <= mem[rd_addr];
    end
  end
endmodule

// ### sfc_strap_capture.sv
`include "sfc_map.svh"
module sfc_strap_capture (
  // Clock and reset.
  input wire logic clk,
  input wire logic rst_b,
  // Pins.
  input wire logic [4:0] pins,
  // Captured mode.
  output logic [1:0] mode_status,
  output logic boot
);
  logic armed_q;

  // Pins are caught once, at the first edge after reset release.
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      armed_q <= 1'b0;
      mode_status <= 2'b00;
      boot <= 1'b0;
    end else if (!armed_q) begin
      armed_q <= 1'b1;
      mode_status <= pins[4:3];
      boot <= (pins == `SFC_BOOT_PINS);
    end
  end
endmodule

// ### sfc_flash_ctrl.sv
// What this block does
// - Boot mode when pins mode1,mode0,strap2..0 read 0,0,1,1,1 at release.
// - Programming runs without any erase block being selected.
// - User programming mode changes only through software control bit writes.
// - One program operation writes 32 bytes.
// - Mode register: expanded bus enable bit 7, mode status bits 1 and 0.
// - Wait register bit 4 opens access to the flash control registers.
// - Control one: flash write enable bit 7, software write enable bit 6.
// - Control two bit 7 shows the flash fault flag.
// - Control two: erase setup bit 1, program setup bit 0.
// - Low four erase selects cover 1-kbyte blocks from address zero, except select 2 at 0800-08FF.
// - Upper four erase selects cover the larger blocks from 1000 upward.
// - The second erase block register address stays unimplemented.
`include "sfc_map.svh"
module sfc_flash_ctrl
  import sfc_pkg::*;
#(
  parameter int PGM_BYTES = 32
) (
  // Clock and reset.
  input wire logic REF_CLK,
  input wire logic RST_B,
  // Mode and strap pins.
  input wire logic MODE_SELECT_PIN_1,
  input wire logic MODE_SELECT_PIN_0,
  input wire logic BOOT_STRAP_PIN_2,
  input wire logic BOOT_STRAP_PIN_1,
  input wire logic BOOT_STRAP_PIN_0,
  // APB slave.
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic PREADY,
  output logic PSLVERR,
  output logic [31:0] PRDATA,
  // Flash array program port.
  output logic FLASH_WR_STB,
  output sfc_pkg::sfc_addr_type FLASH_WR_ADDR,
  output sfc_pkg::sfc_byte_type FLASH_WR_DATA,
  // Flash array erase port.
  output logic FLASH_ERASE_STB,
  output sfc_pkg::sfc_addr_type FLASH_ERASE_LO,
  output sfc_pkg::sfc_addr_type FLASH_ERASE_HI,
  // Flash array verify modes.
  output logic FLASH_VERIFY_ERASE,
  output logic FLASH_VERIFY_PGM,
  // Operating mode.
  output logic EXPANDED_MODE,
  output logic BOOT_MODE,
  output logic USER_PGM_MODE,
  // Interrupt.
  output logic IRQ
);
  import sfc_pkg::*;

  localparam int PW = $clog2(PGM_BYTES);
  localparam logic [PW-1:0] PTR_LAST = PW'(PGM_BYTES - 1);
  localparam sfc_addr_type EB_LO [8] = '{
    `SFC_BLK0_LO, `SFC_BLK1_LO, `SFC_BLK2_LO, `SFC_BLK3_LO,
    `SFC_BLK4_LO, `SFC_BLK5_LO, `SFC_BLK6_LO, `SFC_BLK7_LO
  };
  localparam sfc_addr_type EB_HI [8] = '{
    `SFC_BLK0_HI, `SFC_BLK1_HI, `SFC_BLK2_HI, `SFC_BLK3_HI,
    `SFC_BLK4_HI, `SFC_BLK5_HI, `SFC_BLK6_HI, `SFC_BLK7_HI
  };

  if (PGM_BYTES != 32) begin : g_chk
    $error("sfc_flash_ctrl: program unit must be 32 bytes");
  end

  // Bus state.
  logic pready_q;
  logic pslverr_q;
  logic [31:0] prdata_q;

  // Software registers.
  logic expand_q;
  sfc_byte_type wait_q;
  sfc_byte_type fc1_q;
  logic erase_setup_q;
  logic program_setup_q;
  logic fault_q;
  sfc_byte_type ebs_q;
  sfc_addr_type padr_q;
  logic [PW-1:0] fill_q;
  logic [2:0] ist_q;
  logic [2:0] ien_q;
  logic irq_q;

  // Sequencer.
  sfc_state_type state_q;
  sfc_state_type state_d;
  logic [PW-1:0] ptr_q;
  logic [2:0] blk_q;
  logic wr_stb_q;
  sfc_addr_type wr_addr_q;
  logic er_stb_q;
  sfc_addr_type er_lo_q;
  sfc_addr_type er_hi_q;

  // Captured pins and program buffer read data.
  logic [1:0] mode_status;
  logic boot_w;
  sfc_byte_type buf_rd;

  // Access decode.
  wire access = PSEL & PENABLE;
  wire done = access & pready_q;
  wire wr = done & PWRITE;
  wire gate = wait_q[`SFC_B_GATE];
  wire hit_mode = (PADDR == `SFC_A_MODE);
  wire hit_wait = (PADDR == `SFC_A_WAIT);
  wire hit_fc1 = (PADDR == `SFC_A_FC1);
  wire hit_fc2 = (PADDR == `SFC_A_FC2);
  wire hit_ebs = (PADDR == `SFC_A_EBS);
  wire hit_ebs2 = (PADDR == `SFC_A_EBS2);
  wire hit_padr = (PADDR == `SFC_A_PADR);
  wire hit_pdat = (PADDR == `SFC_A_PDAT);
  wire hit_ist = (PADDR == `SFC_A_IST);
  wire hit_ien = (PADDR == `SFC_A_IEN);
  wire hit_iclr = (PADDR == `SFC_A_ICLR);
  wire mapped = hit_mode | hit_wait | hit_fc1 | hit_fc2 | hit_ebs | hit_ebs2 |
                hit_padr | hit_pdat | hit_ist | hit_ien | hit_iclr;
  wire idle = (state_q == SFC_IDLE);
  wire [7:0] wd = PWDATA[7:0];

  // Writes gated by wait register bit 4, except the interrupt clear write.
  wire wr_fc1 = wr & hit_fc1 & gate;
  wire wr_fc2 = wr & hit_fc2 & gate;
  wire wr_ebs = wr & hit_ebs & gate & idle;
  wire wr_padr = wr & hit_padr & gate & idle;
  wire wr_pdat = wr & hit_pdat & gate & idle;
  wire wr_iclr = wr & hit_iclr;

  // Start requests, taken on a rising start bit.
  wire go_prog = wr_fc1 & wd[`SFC_B_P] & ~fc1_q[`SFC_B_P];
  wire go_erase = wr_fc1 & wd[`SFC_B_E] & ~fc1_q[`SFC_B_E];
  wire en_ok = wd[`SFC_B_FLASH_WE] & wd[`SFC_B_SOFT_WE];
  wire prog_ok = idle & en_ok & program_setup_q;
  wire erase_ok = idle & en_ok & erase_setup_q;
  wire start_prog = go_prog & prog_ok & ~go_erase;
  wire start_erase = go_erase & erase_ok & ~go_prog;
  wire bad_start = (go_prog | go_erase) & ~start_prog & ~start_erase;

  // Sequencer progress.
  wire prog_end = (state_q == SFC_PROG) & (ptr_q == PTR_LAST);
  wire erase_end = (state_q == SFC_ERASE) & (blk_q == 3'd7);
  wire [2:0] irq_set = {bad_start, erase_end, prog_end};
  wire [2:0] irq_clr = wr_iclr ? PWDATA[2:0] : 3'b000;
  wire [2:0] ist_d = (ist_q & ~irq_clr) | irq_set;
  wire fault_clr = wr_fc1 & ~wd[`SFC_B_SOFT_WE];
  wire fault_d = (fault_q & ~fault_clr) | bad_start;

  // Read selection.
  wire [7:0] rd_mode = {expand_q, 5'b0_0000, mode_status};
  wire [7:0] rd_fc1 = gate ? fc1_q : `SFC_RST_BYTE;
  wire [7:0] rd_fc2 = gate ? {fault_q, 5'b0_0000, erase_setup_q, program_setup_q} : `SFC_RST_BYTE;
  wire [7:0] rd_ebs = gate ? ebs_q : `SFC_RST_BYTE;
  wire [15:0] rd_16 = hit_padr ? padr_q :
                      hit_mode ? {8'h00, rd_mode} :
                      hit_wait ? {8'h00, wait_q} :
                      hit_fc1 ? {8'h00, rd_fc1} :
                      hit_fc2 ? {8'h00, rd_fc2} :
                      hit_ebs ? {8'h00, rd_ebs} :
                      hit_ist ? {13'h0000, ist_q} :
                      hit_ien ? {13'h0000, ien_q} : 16'h0000;
  wire [31:0] rdata_d = (access & ~pready_q & ~PWRITE & mapped) ? {16'h0000, rd_16} : 32'h0000_0000;

  always_comb begin
    state_d = state_q;
    case (state_q)
      SFC_IDLE: begin
        if (start_prog) begin
          state_d = SFC_PROG;
        end else if (start_erase) begin
          state_d = SFC_ERASE;
        end
      end
      SFC_PROG: begin
        if (prog_end) begin
          state_d = SFC_IDLE;
        end
      end
      SFC_ERASE: begin
        if (erase_end) begin
          state_d = SFC_IDLE;
        end
      end
      default: begin
        state_d = SFC_IDLE;
      end
    endcase
  end

  // Answer one cycle into the access phase.
  always_ff @(posedge REF_CLK) begin
    if (!RST_B) begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= 32'h0000_0000;
    end else begin
      pready_q <= access & ~pready_q;
      pslverr_q <= access & ~pready_q & ~mapped;
      prdata_q <= rdata_d;
    end
  end

  // Mode and gate registers.
  always_ff @(posedge REF_CLK) begin
    if (!RST_B) begin
      expand_q <= 1'b0;
      wait_q <= `SFC_RST_BYTE;
    end else begin
      if (wr & hit_mode) begin
        expand_q <= wd[`SFC_B_EXPAND];
      end
      if (wr & hit_wait) begin
        wait_q <= wd & `SFC_WAIT_MASK;
      end
    end
  end

  // Flash control registers.
  always_ff @(posedge REF_CLK) begin
    if (!RST_B) begin
      fc1_q <= `SFC_RST_BYTE;
      erase_setup_q <= 1'b0;
      program_setup_q <= 1'b0;
      fault_q <= 1'b0;
      ebs_q <= `SFC_RST_BYTE;
    end else begin
      if (wr_fc1) begin
        fc1_q <= wd & `SFC_FC1_MASK;
      end
      if (wr_fc2) begin
        erase_setup_q <= wd[`SFC_B_ERASE_SU];
        program_setup_q <= wd[`SFC_B_PROG_SU];
      end
      fault_q <= fault_d;
      if (wr_ebs) begin
        ebs_q <= wd;
      end
    end
  end

  // Program buffer fill.
  always_ff @(posedge REF_CLK) begin
    if (!RST_B) begin
      padr_q <= `SFC_RST_ADDR;
      fill_q <= '0;
    end else if (wr_padr) begin
      padr_q <= {PWDATA[15:PW], PW'(0)};
      fill_q <= '0;
    end else if (wr_pdat) begin
      fill_q <= fill_q + PW'(1);
    end
  end

  // Interrupt registers; a set in the cycle of a clear wins.
  always_ff @(posedge REF_CLK) begin
    if (!RST_B) begin
      ist_q <= `SFC_RST_IRQ;
      ien_q <= `SFC_RST_IRQ;
      irq_q <= 1'b0;
    end else begin
      ist_q <= ist_d;
      if (wr & hit_ien) begin
        ien_q <= PWDATA[2:0];
      end
      irq_q <= |(ist_d & ien_q);
    end
  end

  // Sequencer walking bytes or erase blocks.
  always_ff @(posedge REF_CLK) begin
    if (!RST_B) begin
      state_q <= SFC_IDLE;
      ptr_q <= '0;
      blk_q <= 3'd0;
    end else begin
      state_q <= state_d;
      if (state_q == SFC_PROG) begin
        ptr_q <= ptr_q + PW'(1);
      end else begin
        ptr_q <= '0;
      end
      if (state_q == SFC_ERASE) begin
        blk_q <= blk_q + 3'd1;
      end else begin
        blk_q <= 3'd0;
      end
    end
  end

  // Flash array strobes.
  always_ff @(posedge REF_CLK) begin
    if (!RST_B) begin
      wr_stb_q <= 1'b0;
      wr_addr_q <= `SFC_RST_ADDR;
      er_stb_q <= 1'b0;
      er_lo_q <= `SFC_RST_ADDR;
      er_hi_q <= `SFC_RST_ADDR;
    end else begin
      wr_stb_q <= (state_q == SFC_PROG);
      wr_addr_q <= {padr_q[15:PW], ptr_q};
      er_stb_q <= (state_q == SFC_ERASE) & ebs_q[blk_q];
      er_lo_q <= EB_LO[blk_q];
      er_hi_q <= EB_HI[blk_q];
    end
  end

  sfc_pgm_buffer #(
    .WIDTH(8),
    .DEPTH(PGM_BYTES)
  ) u_buf (
    .clk(REF_CLK),
    .rst_b(RST_B),
    .wr_en(wr_pdat),
    .wr_addr(fill_q),
    .wr_data(wd),
    .rd_addr(ptr_q),
    .rd_data(buf_rd)
  );

  sfc_strap_capture u_strap (
    .clk(REF_CLK),
    .rst_b(RST_B),
    .pins({MODE_SELECT_PIN_1, MODE_SELECT_PIN_0, BOOT_STRAP_PIN_2, BOOT_STRAP_PIN_1, BOOT_STRAP_PIN_0}),
    .mode_status(mode_status),
    .boot(boot_w)
  );

  // Outputs straight from flip-flops.
  assign PREADY = pready_q;
  assign PSLVERR = pslverr_q;
  assign PRDATA = prdata_q;
  assign FLASH_WR_STB = wr_stb_q;
  assign FLASH_WR_ADDR = wr_addr_q;
  assign FLASH_WR_DATA = buf_rd;
  assign FLASH_ERASE_STB = er_stb_q;
  assign FLASH_ERASE_LO = er_lo_q;
  assign FLASH_ERASE_HI = er_hi_q;
  assign FLASH_VERIFY_ERASE = fc1_q[`SFC_B_ERASE_VFY];
  assign FLASH_VERIFY_PGM = fc1_q[`SFC_B_PROG_VFY];
  assign EXPANDED_MODE = expand_q;
  assign BOOT_MODE = boot_w;
  assign USER_PGM_MODE = fc1_q[`SFC_B_SOFT_WE];
  assign IRQ = irq_q;
endmodule

// ### sfc_flash_ctrl_checker.sv
`include "sfc_map.svh"
module sfc_flash_ctrl_checker
  import sfc_pkg::*;
#(
  parameter int PGM_BYTES = 32
) (
  // Clock and reset.
  input wire logic REF_CLK,
  input wire logic RST_B,
  // APB.
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  input wire logic PREADY,
  input wire logic PSLVERR,
  input wire logic [31:0] PRDATA,
  // Flash ports and modes.
  input wire logic FLASH_WR_STB,
  input wire sfc_pkg::sfc_addr_type FLASH_WR_ADDR,
  input wire logic FLASH_ERASE_STB,
  input wire sfc_pkg::sfc_addr_type FLASH_ERASE_LO,
  input wire sfc_pkg::sfc_addr_type FLASH_ERASE_HI,
  input wire logic FLASH_VERIFY_ERASE,
  input wire logic FLASH_VERIFY_PGM,
  input wire logic EXPANDED_MODE,
  input wire logic USER_PGM_MODE
);
  default clocking @(posedge REF_CLK); endclocking
  default disable iff (!RST_B);
  logic [7:0] run_q;
  logic [7:0] run_d;
  logic wr_fc1;
  logic wr_mode;
  logic rst_now;
  assign wr_fc1 = PSEL && PENABLE && PREADY && PWRITE && PADDR == `SFC_A_FC1;
  assign wr_mode = PSEL && PENABLE && PREADY && PWRITE && PADDR == `SFC_A_MODE;
  assign rst_now = !RST_B;
  assign run_d = FLASH_WR_STB ? run_q + 8'h01 : 8'h00;
  always_ff @(posedge REF_CLK) begin
    run_q <= RST_B ? run_d : 8'h00;
  end
  chk_upm_by_write: assert property ($rose(USER_PGM_MODE)
    |-> $past(wr_fc1) || $past(wr_fc1, 2)) else $error("user mode rose without write");
  chk_expand_by_write: assert property ($changed(EXPANDED_MODE)
    |-> $past(wr_mode) || $past(wr_mode, 2) || $past(rst_now) || $past(rst_now, 2))
    else $error("expanded mode changed without write");
  chk_verify_by_write: assert property ($changed({FLASH_VERIFY_ERASE, FLASH_VERIFY_PGM})
    |-> $past(wr_fc1) || $past(wr_fc1, 2) || $past(rst_now) || $past(rst_now, 2))
    else $error("verify level changed without write");
  chk_pgm_burst: assert property ($fell(FLASH_WR_STB)
    |-> run_q == 8'(PGM_BYTES)) else $error("program burst length wrong");
  chk_pgm_step: assert property (FLASH_WR_STB && $past(FLASH_WR_STB)
    |-> FLASH_WR_ADDR == $past(FLASH_WR_ADDR) + 16'h0001) else $error("program address not stepping");
  chk_pgm_align: assert property ($rose(FLASH_WR_STB)
    |-> FLASH_WR_ADDR[4:0] == 5'h00) else $error("program burst not aligned");
  chk_low_ranges: assert property (FLASH_ERASE_STB && FLASH_ERASE_LO < 16'h1000
    |-> {FLASH_ERASE_LO, FLASH_ERASE_HI} inside {32'h0000_03FF, 32'h0400_07FF, 32'h0800_08FF, 32'h0C00_0FFF})
    else $error("small erase block range wrong");
  chk_high_ranges: assert property (FLASH_ERASE_STB && FLASH_ERASE_LO >= 16'h1000
    |-> {FLASH_ERASE_LO, FLASH_ERASE_HI} inside {32'h1000_7FFF, 32'h8000_BFFF, 32'hC000_EF7F, 32'hEF00_F77F})
    else $error("large erase block range wrong");
  chk_spare_quiet: assert property (PSEL && PREADY && PADDR == `SFC_A_EBS2
    |-> !PSLVERR && (PWRITE || PRDATA == 32'h0000_0000)) else $error("spare select address answered");
endmodule

// ### sfc_flash_ctrl_bench.sv
`include "sfc_map.svh"
`define CHK(nm, exp, got) begin n_checks++; if ((got) !== (exp)) begin n_errors++; \
  $display("MISMATCH %s expected %h seen %h", nm, exp, got); end end
module sfc_flash_ctrl_bench
  import sfc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk, rst_b, psel, penable, pwrite, pready, pslverr, wr_stb, er_stb;
  logic ver_e, ver_p, expm, boot, upm, irq, er;
  logic [4:0] pins;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  sfc_addr_type wr_addr, er_lo, er_hi;
  sfc_byte_type wr_data;
  int n_errors, n_checks;
  sfc_flash_ctrl #(.PGM_BYTES(32)) sfc_flash_ctrl_inst (.REF_CLK(clk), .RST_B(rst_b),
    .MODE_SELECT_PIN_1(pins[4]), .MODE_SELECT_PIN_0(pins[3]), .BOOT_STRAP_PIN_2(pins[2]),
    .BOOT_STRAP_PIN_1(pins[1]), .BOOT_STRAP_PIN_0(pins[0]), .PSEL(psel), .PENABLE(penable),
    .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PREADY(pready), .PSLVERR(pslverr),
    .PRDATA(prdata), .FLASH_WR_STB(wr_stb), .FLASH_WR_ADDR(wr_addr), .FLASH_WR_DATA(wr_data),
    .FLASH_ERASE_STB(er_stb), .FLASH_ERASE_LO(er_lo), .FLASH_ERASE_HI(er_hi),
    .FLASH_VERIFY_ERASE(ver_e), .FLASH_VERIFY_PGM(ver_p), .EXPANDED_MODE(expm),
    .BOOT_MODE(boot), .USER_PGM_MODE(upm), .IRQ(irq));
  task automatic final_report();
    $display("checks %0d mismatches %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
    @(posedge clk);
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    psel <= 1'b1;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(a, 1'b1, d);
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] exp, input string nm);
    apb(a, 1'b0, 32'h0000_0000);
    `CHK(nm, exp, rd)
  endtask
  task automatic settle();
    repeat (3) @(posedge clk);
  endtask
  task automatic rst(input logic [4:0] p);
    @(posedge clk);
    rst_b <= 1'b0;
    pins <= p;
    repeat (`SFC_RESW_CYC) @(posedge clk);
    rst_b <= 1'b1;
    settle();
  endtask
  task automatic t_mode();
    rst(`SFC_BOOT_PINS);
    `CHK("boot", 1'b1, boot)
    rdc(`SFC_A_MODE, 32'h0000_0000, "mode");
    wr(`SFC_A_MODE, 32'h0000_0083);
    rdc(`SFC_A_MODE, 32'h0000_0080, "mode expand");
    `CHK("expanded", 1'b1, expm)
    pins <= 5'b1_0111;
    settle();
    `CHK("boot held", 1'b1, boot)
    rst(5'b1_0111);
    `CHK("no boot", 1'b0, boot)
    rdc(`SFC_A_MODE, 32'h0000_0002, "mode status");
    $display("test mode done");
  endtask
  task automatic t_gate();
    wr(`SFC_A_FC1, 32'h0000_00C0);
    wr(`SFC_A_EBS, 32'h0000_00FF);
    settle();
    `CHK("upm closed", 1'b0, upm)
    wr(`SFC_A_WAIT, 32'h0000_0010);
    rdc(`SFC_A_WAIT, 32'h0000_0010, "wait");
    rdc(`SFC_A_EBS, 32'h0000_0000, "ebs closed");
    rdc(`SFC_A_FC1, 32'h0000_0000, "fc1 closed");
    wr(`SFC_A_FC1, 32'h0000_00C0);
    rdc(`SFC_A_FC1, 32'h0000_00C0, "fc1");
    `CHK("upm", 1'b1, upm)
    wr(`SFC_A_FC1, 32'h0000_00CC);
    rdc(`SFC_A_FC1, 32'h0000_00CC, "fc1 verify");
    `CHK("verify levels", 2'b11, {ver_e, ver_p})
    wr(`SFC_A_FC1, 32'h0000_00C0);
    wr(`SFC_A_EBS2, 32'h0000_00FF);
    rdc(`SFC_A_EBS2, 32'h0000_0000, "ebs2");
    `CHK("ebs2 err", 1'b0, er)
    apb(8'h3C, 1'b0, 32'h0000_0000);
    `CHK("unmapped err", 1'b1, er)
    $display("test gate done");
  endtask
  task automatic t_fault();
    wr(`SFC_A_FC2, 32'h0000_0000);
    wr(`SFC_A_FC1, 32'h0000_00C1);
    rdc(`SFC_A_FC2, 32'h0000_0080, "fault");
    rdc(`SFC_A_IST, 32'h0000_0004, "status");
    `CHK("irq masked", 1'b0, irq)
    wr(`SFC_A_IEN, 32'h0000_0004);
    settle();
    `CHK("irq on", 1'b1, irq)
    wr(`SFC_A_ICLR, 32'h0000_0004);
    settle();
    `CHK("irq off", 1'b0, irq)
    wr(`SFC_A_FC1, 32'h0000_0080);
    rdc(`SFC_A_FC2, 32'h0000_0000, "fault clr");
    wr(`SFC_A_FC1, 32'h0000_00C0);
    $display("test fault done");
  endtask
  task automatic t_prog();
    int k;
    wr(`SFC_A_EBS, 32'h0000_0000);
    wr(`SFC_A_PADR, 32'h0000_1234);
    for (int i = 0; i < 32; i++) begin
      wr(`SFC_A_PDAT, {24'h00_0000, 8'h5A ^ 8'(i)});
    end
    wr(`SFC_A_FC2, 32'h0000_0001);
    wr(`SFC_A_FC1, 32'h0000_00C1);
    k = 0;
    repeat (40) begin
      @(posedge clk);
      if (wr_stb === 1'b1) begin
        `CHK("pgm addr", 16'h1220 + 16'(k), wr_addr)
        `CHK("pgm data", 8'h5A ^ 8'(k), wr_data)
        k++;
      end
    end
    `CHK("pgm count", 32, k)
    rdc(`SFC_A_IST, 32'h0000_0001, "pgm done");
    wr(`SFC_A_ICLR, 32'h0000_0001);
    wr(`SFC_A_FC1, 32'h0000_00C0);
    $display("test program done");
  endtask
  task automatic t_erase();
    sfc_addr_type lo [4];
    sfc_addr_type hi [4];
    int j;
    lo = '{`SFC_BLK1_LO, `SFC_BLK3_LO, `SFC_BLK4_LO, `SFC_BLK6_LO};
    hi = '{`SFC_BLK1_HI, `SFC_BLK3_HI, `SFC_BLK4_HI, `SFC_BLK6_HI};
    wr(`SFC_A_FC2, 32'h0000_0002);
    wr(`SFC_A_EBS, 32'h0000_005A);
    wr(`SFC_A_FC1, 32'h0000_00C2);
    j = 0;
    repeat (15) begin
      @(posedge clk);
      `CHK("no prewrite", 1'b0, wr_stb)
      if (er_stb === 1'b1) begin
        `CHK("erase lo", lo[j & 3], er_lo)
        `CHK("erase hi", hi[j & 3], er_hi)
        j++;
      end
    end
    `CHK("erase count", 4, j)
    rdc(`SFC_A_IST, 32'h0000_0002, "erase done");
    wr(`SFC_A_FC1, 32'h0000_00C0);
    $display("test erase done");
  endtask
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  initial begin
    #500000;
    n_errors++;
    final_report();
  end
  initial begin
    rst_b = 1'b0;
    pins = `SFC_BOOT_PINS;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
    n_errors = 0;
    n_checks = 0;
    repeat (2) @(posedge clk);
    rst_b <= 1'b1;
    t_mode();
    t_gate();
    t_fault();
    t_prog();
    t_erase();
    final_report();
  end
endmodule
bind sfc_flash_ctrl sfc_flash_ctrl_checker #(.PGM_BYTES(PGM_BYTES)) sfc_flash_ctrl_checker_inst (
  .REF_CLK(REF_CLK), .RST_B(RST_B), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR),
  .PREADY(PREADY), .PSLVERR(PSLVERR), .PRDATA(PRDATA), .FLASH_WR_STB(FLASH_WR_STB),
  .FLASH_WR_ADDR(FLASH_WR_ADDR), .FLASH_ERASE_STB(FLASH_ERASE_STB), .FLASH_ERASE_LO(FLASH_ERASE_LO),
  .FLASH_ERASE_HI(FLASH_ERASE_HI), .FLASH_VERIFY_ERASE(FLASH_VERIFY_ERASE),
  .FLASH_VERIFY_PGM(FLASH_VERIFY_PGM), .EXPANDED_MODE(EXPANDED_MODE), .USER_PGM_MODE(USER_PGM_MODE));
